// File: bench/timer_slice_service_request_tb.sv
// Purpose: Self-checking bench of the timer slice service request block
// Assumes: Inputs change 1 ns after the rising edge of clk_i
// Notes:   Expected values are worked out here; only the suspend test reads status back as its expected value
`timescale 1ns/1ps
`include "tssr_cfg.svh"

module timer_slice_service_request_tb;
    logic                                   clk_i, reset_n_i, susp_req, pre_set, pre_clr;
    logic [`NUM_SLICES-1:0]                 pm_up, om_dn, cm_up, cm_dn, fault, sl_set, sl_clr;
    logic [`NUM_SLICES-1:0][`NUM_EXT-1:0]   ev_pin;
    logic [`NUM_SLICES-1:0][2*`NUM_EXT-1:0] edge_sel;
    logic [`NUM_SLICES-1:0][`NUM_SRC-1:0]   irq_set, irq_clr, irq_en, status, snap;
    logic [`NUM_SLICES-1:0][2*`NUM_SRC-1:0] route;
    logic [`NUM_EXT-1:0]                    ext_clk;
    logic [1:0]                             clk_sel, susp_cfg;
    logic [`NUM_SLICES-1:0]                 trap_flag, sl_idle, sl_run;
    logic [`NUM_LINES-1:0]                  srq;
    logic                                   suspended, prescaler_run_bit, pre_run, tick, pdown, ext_run;
    logic [7:0]                             rise_cnt, tick_cnt, t0, r0;
    int                                     err_count, tests_run;

    timer_slice_service_request uut (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .period_match_up_src_i(pm_up),
        .one_match_down_src_i(om_dn), .compare_match_up_src_i(cm_up),
        .compare_match_down_src_i(cm_dn), .fault_stop_i(fault), .ext_event_pin_i(ev_pin),
        .event_edge_select_i(edge_sel), .slice_irq_set_i(irq_set),
        .slice_irq_clear_i(irq_clr), .slice_irq_enable_i(irq_en),
        .slice_request_routing_i(route), .ext_clk_pin_i(ext_clk),
        .clock_source_select_i(clk_sel), .suspend_req_i(susp_req),
        .suspend_config_field_i(susp_cfg), .idle_set_prescaler_i(pre_set),
        .idle_clear_prescaler_i(pre_clr), .idle_set_slice_i(sl_set),
        .idle_clear_slice_i(sl_clr), .slice_irq_status_o(status),
        .trap_status_flag_o(trap_flag), .service_request_o(srq), .suspended_o(suspended),
        .prescaler_run_bit_o(prescaler_run_bit), .slice_idle_o(sl_idle), .slice_run_o(sl_run),
        .prescaler_run_o(pre_run), .prescaler_tick_o(tick), .power_down_o(pdown)
    );

    tssr_partner partner (
        .clk_i(clk_i), .run_i(ext_run), .sel_i(clk_sel), .ext_clk_o(ext_clk),
        .rise_count_o(rise_cnt)
    );

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        if (tick === 1'b1) tick_cnt <= tick_cnt + 8'h01;
    end

    task automatic step();
        @(posedge clk_i);
        #1;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
            err_count++;
        end
    endtask

    task automatic wait_susp(input logic lvl);
        int n;
        n = 0;
        while (suspended !== lvl && n < 10) begin
            step();
            n++;
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic t_reset();
        check("status", status, 32'h0);
        check("request", srq, 32'h0);
        check("run bit", prescaler_run_bit, `PRB_RESET);
        check("slice idle", sl_idle, `SLICE_IDLE_RESET);
        check("power down", pdown, 32'h1);
    endtask

    task automatic t_run_ctrl();
        pre_clr = 1'b1;
        step();
        pre_clr = 1'b0;
        check("run bit", prescaler_run_bit, 32'h1);
        check("power down", pdown, 32'h0);
        sl_clr = 4'hf;
        step();
        sl_clr = 4'h0;
        check("slice run", sl_run, 32'hf);
        pre_set = 1'b1;
        step();
        pre_set = 1'b0;
        check("slice run", sl_run, 32'h0);
        check("prescaler run", pre_run, 32'h0);
        pre_clr = 1'b1;
        step();
        pre_clr = 1'b0;
    endtask

    task automatic t_events();
        cm_up[0] = 1'b1;
        step();
        cm_up[0] = 1'b0;
        check("status 0", status[0], 32'h02);
        check("request", srq, 32'h4);
        step();
        check("request", srq, 32'h0);
        cm_dn[0] = 1'b1;
        step();
        cm_dn[0] = 1'b0;
        check("request", srq, 32'h4);
        om_dn[1] = 1'b1;
        cm_dn[2] = 1'b1;
        step();
        {om_dn[1], cm_dn[2]} = 2'h0;
        check("status 1", status[1], 32'h01);
        check("request", srq, 32'hc);
        pm_up = 4'h9;
        step();
        pm_up = 4'h0;
        check("status 3", status[3], 32'h01);
        check("request", srq, 32'h1);
    endtask

    task automatic t_sw();
        irq_clr = 24'hffffff;
        step();
        irq_clr = 24'h0;
        check("status", status, 32'h0);
        irq_set[1] = 6'h2a;
        step();
        irq_set[1] = 6'h00;
        check("status 1", status[1], 32'h2a);
        check("request", srq, 32'h0);
        irq_clr[1] = 6'h08;
        step();
        irq_clr = 24'hffffff;
        check("status 1", status[1], 32'h22);
        step();
        irq_clr = 24'h0;
    endtask

    task automatic t_ext();
        ev_pin[0][1] = 1'b1;
        repeat (3) step();
        check("request", srq, 32'h2);
        check("status 0", status[0], 32'h08);
        ev_pin[0][1] = 1'b0;
        repeat (3) step();
        check("request", srq, 32'h2);
        ev_pin[0][0] = 1'b1;
        repeat (3) step();
        check("request", srq, 32'h8);
        ev_pin[0][0] = 1'b0;
        repeat (3) step();
        check("request", srq, 32'h0);
    endtask

    task automatic t_trap();
        fault[0] = 1'b1;
        step();
        check("trap flag", trap_flag, 32'h1);
        check("request", srq, 32'h8);
        step();
        fault[0] = 1'b0;
        check("request", srq, 32'h0);
    endtask

    task automatic t_susp();
        susp_req = 1'b1;
        repeat (5) step();
        check("suspended", suspended, 32'h0);
        susp_cfg = 2'h1;
        wait_susp(1'b1);
        check("suspended", suspended, 32'h1);
        check("prescaler run", pre_run, 32'h0);
        check("slice run", sl_run, 32'h0);
        snap = status;
        cm_up[0] = 1'b1;
        irq_set[2] = 6'h01;
        step();
        {cm_up[0], irq_set[2]} = 7'h00;
        step();
        check("status", status, snap);
        check("request", srq, 32'h0);
        check("run bit", prescaler_run_bit, 32'h1);
        susp_req = 1'b0;
        step();
        check("suspended", suspended, 32'h1);
        wait_susp(1'b0);
        check("slice run", sl_run, 32'hf);
        check("prescaler run", pre_run, 32'h1);
    endtask

    task automatic t_clk();
        // Tick trails the run flag by one cycle after resume
        step();
        t0 = tick_cnt;
        repeat (10) step();
        check("internal ticks", tick_cnt - t0, 32'ha);
        for (int s = 1; s < 4; s++) begin
            clk_sel = s[1:0];
            repeat (3) step();
            t0 = tick_cnt;
            r0 = rise_cnt;
            ext_run = 1'b1;
            repeat (60) step();
            ext_run = 1'b0;
            repeat (16) step();
            check("ext rises", (rise_cnt - r0) > 8'h4, 32'h1);
            check("ext ticks", tick_cnt - t0, rise_cnt - r0);
        end
    endtask

    initial begin
        {reset_n_i, susp_req, pre_set, pre_clr, pm_up, om_dn, cm_up, cm_dn, fault} = '0;
        {sl_set, sl_clr, ev_pin, irq_set, irq_clr, clk_sel, susp_cfg, ext_run} = '0;
        {err_count, tests_run, tick_cnt} = '0;
        irq_en   = {6'h00, 6'h3f, 6'h3f, 6'h3f};
        edge_sel = {18'h0, 6'h0d};
        route    = {12'h000, 12'h008, 12'h003, 12'hc78};
        repeat (6) @(posedge clk_i);
        #1;
        reset_n_i = 1'b1;
        t_reset();
        t_run_ctrl();
        t_events();
        t_sw();
        t_ext();
        t_trap();
        t_susp();
        t_clk();
        sl_set  = 4'hf;
        pre_set = 1'b1;
        step();
        check("power down", pdown, 32'h1);
        wrap_up();
    end

    initial begin
        #200000;
        err_count++;
        wrap_up();
    end
endmodule

// File: bench/tssr_partner.sv
// Purpose: External prescaler clock source standing outside the timer unit
// Assumes: Only one of the three clock pins is active at a time
// Notes:   Clock stands low between bursts; phase offset keeps it unrelated
`timescale 1ns/1ps
`include "tssr_cfg.svh"

module tssr_partner (
    input  wire logic                 clk_i,
    input  wire logic                 run_i,
    input  wire logic [1:0]           sel_i,
    output logic      [`NUM_EXT-1:0]  ext_clk_o,
    output logic      [7:0]           rise_count_o
);
    initial begin
        ext_clk_o    = 3'h0;
        rise_count_o = 8'h00;
        forever begin
            @(posedge clk_i);
            if (run_i === 1'b1 && sel_i !== 2'h0) begin
                #7;
                ext_clk_o[sel_i - 2'h1] = 1'b1;
                rise_count_o = rise_count_o + 8'h01;
                // Four module periods high and five low, well under a quarter rate
                #160;
                ext_clk_o = 3'h0;
                #160;
            end
        end
    end
endmodule

// File: hdl/pin_sync.sv
// Purpose: Two-flop synchroniser for pins entering the module clock domain
// Assumes: Inputs are asynchronous levels
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ps
`include "tssr_cfg.svh"

module pin_sync (
    input  wire logic                 clk_i,
    input  wire logic                 reset_n_i,
    input  wire logic [`SYNC_W-1:0]   async_i,
    output logic      [`SYNC_W-1:0]   sync_o
);

    tssr_pkg::sync_state_s q;
    tssr_pkg::sync_state_s next_q;

    always_comb begin
        next_q      = q;
        next_q.meta = async_i;
        next_q.sync = q.meta;
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign sync_o = q.sync;

endmodule

// File: hdl/timer_slice_service_request.sv
// Purpose: Service request generation and global run control of a timer unit
// Assumes: Slice match and fault-stop inputs are on clk_i; pins are not
// Notes:   Request lines pulse one cycle per event; status bits are sticky
`timescale 1ns/1ps
`include "tssr_cfg.svh"

module timer_slice_service_request (
    input  wire logic                                    clk_i,
    input  wire logic                                    reset_n_i,
    input  wire logic [`NUM_SLICES-1:0]                  period_match_up_src_i,
    input  wire logic [`NUM_SLICES-1:0]                  one_match_down_src_i,
    input  wire logic [`NUM_SLICES-1:0]                  compare_match_up_src_i,
    input  wire logic [`NUM_SLICES-1:0]                  compare_match_down_src_i,
    input  wire logic [`NUM_SLICES-1:0]                  fault_stop_i,
    input  wire logic [`NUM_SLICES-1:0][`NUM_EXT-1:0]    ext_event_pin_i,
    input  wire logic [`NUM_SLICES-1:0][2*`NUM_EXT-1:0]  event_edge_select_i,
    input  wire logic [`NUM_SLICES-1:0][`NUM_SRC-1:0]    slice_irq_set_i,
    input  wire logic [`NUM_SLICES-1:0][`NUM_SRC-1:0]    slice_irq_clear_i,
    input  wire logic [`NUM_SLICES-1:0][`NUM_SRC-1:0]    slice_irq_enable_i,
    input  wire logic [`NUM_SLICES-1:0][2*`NUM_SRC-1:0]  slice_request_routing_i,
    input  wire logic [`NUM_EXT-1:0]                     ext_clk_pin_i,
    input  wire logic [1:0]                              clock_source_select_i,
    input  wire logic                                    suspend_req_i,
    input  wire logic [1:0]                              suspend_config_field_i,
    input  wire logic                                    idle_set_prescaler_i,
    input  wire logic                                    idle_clear_prescaler_i,
    input  wire logic [`NUM_SLICES-1:0]                  idle_set_slice_i,
    input  wire logic [`NUM_SLICES-1:0]                  idle_clear_slice_i,
    output logic      [`NUM_SLICES-1:0][`NUM_SRC-1:0]    slice_irq_status_o,
    output logic      [`NUM_SLICES-1:0]                  trap_status_flag_o,
    output logic      [`NUM_LINES-1:0]                   service_request_o,
    output logic                                         suspended_o,
    output logic                                         prescaler_run_bit_o,
    output logic      [`NUM_SLICES-1:0]                  slice_idle_o,
    output logic      [`NUM_SLICES-1:0]                  slice_run_o,
    output logic                                         prescaler_run_o,
    output logic                                         prescaler_tick_o,
    output logic                                         power_down_o
);

    localparam tssr_pkg::core_state_s RESET_STATE = '{
        state:      tssr_pkg::ST_RUN,
        prescaler_run_bit:        `PRB_RESET,
        slice_idle: `SLICE_IDLE_RESET,
        power_down: 1'h1,
        default:    '0
    };

    tssr_pkg::core_state_s                       q;
    tssr_pkg::core_state_s                       next_q;
    logic [`SYNC_W-1:0]                          sync_in;
    logic [`SYNC_W-1:0]                          sync_out;
    logic [`NUM_SLICES-1:0][`NUM_EXT-1:0]        ev_sync;
    logic [`NUM_EXT-1:0]                         clk_sync;
    logic                                        susp_sync;
    logic [`NUM_SLICES-1:0][`NUM_EXT-1:0]        ext_edge;
    logic [`NUM_SLICES-1:0][`NUM_SRC-1:0]        hw_evt;
    logic [`NUM_SLICES-1:0][`NUM_LINES-1:0]      line_req;
    logic [`NUM_LINES-1:0]                       unit_req;
    logic                                        suspended_now;
    logic                                        raw_tick;

    // Pins and the debug request cross into clk_i here
    assign sync_in = {suspend_req_i, ext_clk_pin_i, ext_event_pin_i};

    pin_sync u_pin_sync (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .async_i   (sync_in),
        .sync_o    (sync_out)
    );

    assign ev_sync       = sync_out[`SYNC_EV_LSB +: `NUM_SLICES*`NUM_EXT];
    assign clk_sync      = sync_out[`SYNC_CLK_LSB +: `NUM_EXT];
    assign susp_sync     = sync_out[`SYNC_SUSP_BIT];
    assign suspended_now = (q.state == tssr_pkg::ST_SUSP);

    // Per-slice source merging, edge detection and node pointer routing
    genvar s;
    genvar e;
    genvar k;
    genvar b;
    generate
        for (s = 0; s < `NUM_SLICES; s++) begin : g_slice
            logic [`NUM_LINES-1:0][`NUM_SRC-1:0] route_hit;
            for (e = 0; e < `NUM_EXT; e++) begin : g_ext
                // Edge select acts even when the event also drives a level function
                assign ext_edge[s][e] =
                    (ev_sync[s][e] & ~q.ev_hist[s][e]
                        & event_edge_select_i[s][2*e+`EDGE_RISE_BIT])
                  | (~ev_sync[s][e] & q.ev_hist[s][e]
                        & event_edge_select_i[s][2*e+`EDGE_FALL_BIT]);
            end
            // Frozen slices produce no events while suspended
            assign hw_evt[s] = {`NUM_SRC{~suspended_now}} & {
                fault_stop_i[s] & ~q.trap_hist[s],
                ext_edge[s],
                compare_match_up_src_i[s] | compare_match_down_src_i[s],
                period_match_up_src_i[s] | one_match_down_src_i[s]
            };
            for (k = 0; k < `NUM_LINES; k++) begin : g_line
                for (b = 0; b < `NUM_SRC; b++) begin : g_src
                    assign route_hit[k][b] =
                        (slice_request_routing_i[s][`ROUTE_W*b +: `ROUTE_W]
                            == `ROUTE_W'(k));
                end
                // Status bit is not consulted, so repeats still pulse
                assign line_req[s][k] =
                    |(hw_evt[s] & slice_irq_enable_i[s] & route_hit[k]);
            end
        end
    endgenerate

    always_comb begin
        unit_req = '0;
        for (int i = 0; i < `NUM_SLICES; i++) begin
            unit_req = unit_req | line_req[i];
        end
    end

    // Prescaler tick source; external clocks count rising edges only
    always_comb begin
        case (clock_source_select_i)
            `CLKSRC_INTERNAL: raw_tick = 1'b1;
            `CLKSRC_EXT_A:    raw_tick = clk_sync[0] & ~q.clk_hist[0];
            `CLKSRC_EXT_B:    raw_tick = clk_sync[1] & ~q.clk_hist[1];
            `CLKSRC_EXT_C:    raw_tick = clk_sync[2] & ~q.clk_hist[2];
            default:          raw_tick = 1'b0;
        endcase
    end

    always_comb begin
        next_q           = q;
        next_q.ev_hist   = ev_sync;
        next_q.clk_hist  = clk_sync;
        next_q.trap_hist = fault_stop_i;

        case (q.state)
            tssr_pkg::ST_RUN: begin
                if (susp_sync && (suspend_config_field_i != `SUSPEND_CONFIG_FIELD_IGNORE)) begin
                    next_q.state = tssr_pkg::ST_SUSP;
                end
            end
            tssr_pkg::ST_SUSP: begin
                if (!susp_sync) begin
                    next_q.state = tssr_pkg::ST_RUN;
                end
            end
            default: begin
                next_q.state = tssr_pkg::ST_RUN;
            end
        endcase

        // Writes are dropped while suspended; state change touches no bits
        for (int i = 0; i < `NUM_SLICES; i++) begin
            if (!suspended_now) begin
                next_q.status[i] = (q.status[i] & ~slice_irq_clear_i[i])
                                 | slice_irq_set_i[i];
            end
            // Hardware set wins over a same-cycle clear
            next_q.status[i] = next_q.status[i] | hw_evt[i];
        end

        // Run request wins over idle request when both arrive together
        if (!suspended_now) begin
            if (idle_clear_prescaler_i) begin
                next_q.prescaler_run_bit = 1'b1;
            end else if (idle_set_prescaler_i) begin
                next_q.prescaler_run_bit = 1'b0;
            end
            next_q.slice_idle = (q.slice_idle | idle_set_slice_i)
                              & ~idle_clear_slice_i;
        end

        next_q.service_request = unit_req;
        next_q.prescaler_run   = next_q.prescaler_run_bit
                               & (next_q.state == tssr_pkg::ST_RUN);
        next_q.slice_run       = ~next_q.slice_idle
                               & {`NUM_SLICES{next_q.prescaler_run}};
        next_q.tick            = raw_tick & q.prescaler_run;
        next_q.power_down      = (next_q.prescaler_run_bit == `PRB_RESET)
                               && (next_q.slice_idle == `SLICE_IDLE_RESET);
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            q <= RESET_STATE;
        end else begin
            q <= next_q;
        end
    end

    assign slice_irq_status_o  = q.status;
    assign service_request_o   = q.service_request;
    assign suspended_o         = suspended_now;
    assign prescaler_run_bit_o = q.prescaler_run_bit;
    assign slice_idle_o        = q.slice_idle;
    assign slice_run_o         = q.slice_run;
    assign prescaler_run_o     = q.prescaler_run;
    assign prescaler_tick_o    = q.tick;
    assign power_down_o        = q.power_down;

    generate
        for (s = 0; s < `NUM_SLICES; s++) begin : g_trap
            assign trap_status_flag_o[s] = q.status[s][`SRC_TRAP];
        end
    endgenerate

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    sequence s_sw_set_slice1;
        !suspended_o && slice_irq_set_i[1][`SRC_EV1];
    endsequence

    sequence s_sw_clear_slice0;
        !suspended_o && slice_irq_clear_i[0][`SRC_EV0]
            && !slice_irq_set_i[0][`SRC_EV0] && !hw_evt[0][`SRC_EV0];
    endsequence

    sequence s_trap_entry;
        !suspended_o && !fault_stop_i[0] ##1 !suspended_o && fault_stop_i[0];
    endsequence

    sequence s_repeat_cm_slice0;
        hw_evt[0][`SRC_CM] && slice_irq_enable_i[0][`SRC_CM]
            && slice_irq_status_o[0][`SRC_CM];
    endsequence

    sequence s_ext_rise_a;
        !clk_sync[0] ##1 clk_sync[0] && prescaler_run_o
            && clock_source_select_i == `CLKSRC_EXT_A;
    endsequence

    sequence s_ext_rise_c;
        !clk_sync[2] ##1 clk_sync[2] && prescaler_run_o
            && clock_source_select_i == `CLKSRC_EXT_C;
    endsequence

    sequence s_susp_exit;
        suspended_o ##1 !suspended_o;
    endsequence

    property p_route_cm;
        logic [`ROUTE_W-1:0] ln;
        (hw_evt[0][`SRC_CM] && slice_irq_enable_i[0][`SRC_CM],
            ln = slice_request_routing_i[0][`ROUTE_W*`SRC_CM +: `ROUTE_W])
            |=> service_request_o[ln];
    endproperty

    AST_SW_SET: assert property (s_sw_set_slice1 |=> slice_irq_status_o[1][`SRC_EV1])
        else $error("software set did not set status");
    AST_SW_CLEAR: assert property (s_sw_clear_slice0 |=> !slice_irq_status_o[0][`SRC_EV0])
        else $error("software clear did not clear status");
    AST_RECORD_DISABLED: assert property (
        !suspended_o && period_match_up_src_i[3] && !slice_irq_enable_i[3][`SRC_PM]
            |=> slice_irq_status_o[3][`SRC_PM])
        else $error("disabled event not recorded");
    AST_MERGE_CM: assert property (
        !suspended_o && compare_match_down_src_i[2] |=> slice_irq_status_o[2][`SRC_CM])
        else $error("compare down did not set merged bit");
    AST_ROUTE: assert property (p_route_cm)
        else $error("enabled event missed its request line");
    AST_REPEAT_PULSE: assert property (s_repeat_cm_slice0 |=> service_request_o != '0)
        else $error("repeated event did not pulse again");
    AST_LINE_OR: assert property (line_req[1][3] |=> service_request_o[3])
        else $error("slice line missing from unit line");
    AST_TRAP_ENTRY: assert property (s_trap_entry |=> trap_status_flag_o[0])
        else $error("fault-stop entry did not set trap flag");
    AST_TRAP_REQ: assert property (
        s_trap_entry ##0 slice_irq_enable_i[0][`SRC_TRAP] |=> service_request_o != '0)
        else $error("fault-stop entry raised no request");
    AST_EDGE_BOTH: assert property (
        !suspended_o && event_edge_select_i[0][3:2] == 2'h3 && $changed(ev_sync[0][1])
            |=> slice_irq_status_o[0][`SRC_EV1])
        else $error("both-edge event missed a transition");
    AST_EV0_NO_FALL: assert property (
        !event_edge_select_i[0][`EDGE_FALL_BIT] && $fell(ev_sync[0][0])
            |-> !hw_evt[0][`SRC_EV0])
        else $error("unselected falling edge raised an event");
    AST_SUSP_FREEZE: assert property (
        suspended_o |-> !prescaler_run_o && (slice_run_o == '0))
        else $error("clocks run while suspended");
    AST_SUSP_RO: assert property (
        suspended_o && $past(suspended_o) && (hw_evt == '0) ##1 suspended_o
            |-> $stable(slice_irq_status_o) && $stable(prescaler_run_bit_o))
        else $error("register changed while suspended");
    AST_EXIT_KEEP: assert property (
        s_susp_exit |-> $stable(slice_irq_status_o) && $stable(slice_idle_o)
            && $stable(prescaler_run_bit_o))
        else $error("register changed on suspend exit");
    AST_SUSP_CFG: assert property (
        !suspended_o && suspend_config_field_i == `SUSPEND_CONFIG_FIELD_IGNORE |=> !suspended_o)
        else $error("suspend honoured while ignored");
    AST_SUSP_ENTER: assert property (
        !suspended_o && susp_sync && suspend_config_field_i != `SUSPEND_CONFIG_FIELD_IGNORE
            |=> suspended_o)
        else $error("honoured suspend request not entered");
    AST_RESUME: assert property (
        suspended_o && susp_sync |=> suspended_o ##0 !prescaler_run_o)
        else $error("resumed while suspend still active");
    AST_SUSP_EXIT: assert property (suspended_o && !susp_sync |=> !suspended_o)
        else $error("suspend kept after request dropped");
    AST_GATE: assert property (!prescaler_run_bit_o |-> slice_run_o == '0)
        else $error("slice runs with prescaler stopped");
    AST_INT_TICK: assert property (
        clock_source_select_i == `CLKSRC_INTERNAL && prescaler_run_o
            |=> prescaler_tick_o)
        else $error("internal prescaler missed a tick");
    AST_TICK_STOP: assert property (!prescaler_run_o |=> !prescaler_tick_o)
        else $error("prescaler ticked while stopped");
    AST_EXT_RISE: assert property (
        clock_source_select_i == `CLKSRC_EXT_B && !(clk_sync[1] && !q.clk_hist[1])
            |=> !prescaler_tick_o)
        else $error("prescaler ticked without rising edge");
    AST_EXT_A_TICK: assert property (s_ext_rise_a |=> prescaler_tick_o)
        else $error("external clock A rise gave no tick");
    AST_EXT_C_TICK: assert property (s_ext_rise_c |=> prescaler_tick_o)
        else $error("external clock C rise gave no tick");
    AST_POWER_DOWN: assert property (power_down_o |-> !prescaler_run_o)
        else $error("power-down with prescaler running");
    AST_POWER_VALUE: assert property (
        power_down_o == (!prescaler_run_bit_o && (slice_idle_o == `SLICE_IDLE_RESET)))
        else $error("power-down flag disagrees with run status");

endmodule

// File: hdl/tssr_cfg.svh
// Purpose: Constants for the timer slice service request block
// Assumes: Four slices, six merged interrupt sources per slice, four lines
// Notes:   Widths and counts are fixed; no bus, all control bits are ports
`ifndef TSSR_CFG_SVH
`define TSSR_CFG_SVH

`define NUM_SLICES        4
`define NUM_SRC           6
`define NUM_LINES         4
`define NUM_EXT           3
`define ROUTE_W           2
`define SYNC_W            16

// Status bit positions of the merged sources
`define SRC_PM            0
`define SRC_CM            1
`define SRC_EV0           2
`define SRC_EV1           3
`define SRC_EV2           4
`define SRC_TRAP          5

// Edge select field bits, two per external event
`define EDGE_RISE_BIT     0
`define EDGE_FALL_BIT     1

// Synchroniser lane layout
`define SYNC_EV_LSB       0
`define SYNC_CLK_LSB      12
`define SYNC_SUSP_BIT     15

// Prescaler clock source select codes
`define CLKSRC_INTERNAL   2'h0
`define CLKSRC_EXT_A      2'h1
`define CLKSRC_EXT_B      2'h2
`define CLKSRC_EXT_C      2'h3

// Suspend configuration code that ignores the debug request
`define SUSPEND_CONFIG_FIELD_IGNORE     2'h0

// Global run status reset values
`define PRB_RESET         1'h0
`define SLICE_IDLE_RESET  4'hf

`endif

// File: hdl/tssr_pkg.sv
// Purpose: Types for the timer slice service request block
// Assumes: Constants come from tssr_cfg.svh
// Notes:   State of each module is one packed struct
`include "tssr_cfg.svh"

package tssr_pkg;

    typedef enum logic [0:0] {
        ST_RUN  = 1'b0,
        ST_SUSP = 1'b1
    } run_state_e;

    typedef struct packed {
        logic [`SYNC_W-1:0] meta;
        logic [`SYNC_W-1:0] sync;
    } sync_state_s;

    typedef struct packed {
        run_state_e                                 state;
        logic [`NUM_SLICES-1:0][`NUM_SRC-1:0]       status;
        logic [`NUM_SLICES-1:0][`NUM_EXT-1:0]       ev_hist;
        logic [`NUM_SLICES-1:0]                     trap_hist;
        logic [`NUM_EXT-1:0]                        clk_hist;
        logic [`NUM_LINES-1:0]                      service_request;
        logic                                       prescaler_run_bit;
        logic [`NUM_SLICES-1:0]                     slice_idle;
        logic [`NUM_SLICES-1:0]                     slice_run;
        logic                                       prescaler_run;
        logic                                       tick;
        logic                                       power_down;
    } core_state_s;

endpackage
